// ===== design/sei_i2c_port.sv
`timescale 1ns/1ps
// Overview of operation
// - byte after the write address selects what the packet does
// - selector 0x00 clears the buffer pointers to the first location
// - selector 0x01 enters sleep, clears volatile state, ignores bus
// - selector 0x02 enters idle, ignores bus, keeps key and digest state
// - selector 0x03 stores following bytes at consecutive input slots
// - after resync the read address is acked unless part of a command is held; data may float as 0xFF
// - address, 0x01, stop sleeps when awake and not busy, resets all
// - watchdog expiry while awake puts the device to sleep
// - wake from idle restarts the watchdog and keeps state
// - with no result a read gives count 4, status and two CRC bytes
// - address bits 7:1 match configured address, bit 0 one is read
// - read group is count, status or result packet, then 2-byte CRC
// - each read byte is the next sequential output buffer byte
// - read address is nacked while busy, idle or asleep
// - read address is nacked while only part of a command is held
// - stop with a complete command makes the device busy and start it
// - first command byte is the count; later excess bytes are dropped
module sei_i2c_port #(
  parameter int unsigned WAKE_HIGH_CYC = sei_pkg::WAKE_HIGH_CYC,
  parameter int unsigned WATCHDOG_CYC  = sei_pkg::WATCHDOG_CYC
) (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n_o,
  input  wire logic [6:0]         bus_addr_i,
  input  wire sei_pkg::sei_out_s  out_buf_i,
  output logic [7:0]              out_idx_o,
  output sei_pkg::sei_in_wr_s     in_wr_o,
  output logic                    exec_start_o,
  input  wire logic               exec_done_i,
  output logic                    vol_clear_o,
  output logic                    awake_o,
  output logic                    idle_o,
  output logic                    busy_o
);

  logic [2:0]        scl_sync;
  logic [2:0]        sda_sync;
  logic              scl_f_reg;
  logic              sda_f_reg;
  logic              scl_d_reg;
  logic              sda_d_reg;
  sei_pkg::sei_bus_e st_reg;
  sei_pkg::sei_pwr_e pw_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        tx_reg;
  logic              first_reg;
  logic              rd_reg;
  logic              mack_reg;
  logic              oe_n_reg;
  logic [7:0]        func_reg;
  logic [7:0]        in_cnt_reg;
  logic [7:0]        count_reg;
  logic [7:0]        out_ptr_reg;
  logic [31:0]       wake_cnt_reg;
  logic [31:0]       wdog_cnt_reg;
  logic              vol_clear_reg;
  logic              exec_start_reg;
  sei_pkg::sei_in_wr_s in_wr_reg;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       fall8;
  logic       addr_done;
  logic       addr_ok;
  logic       wa_done;
  logic       wd_done;
  logic       tx_load;
  logic       cmd_full;
  logic       cmd_part;
  logic       cmd_go;
  logic       go_sleep;
  logic       go_idle;
  logic       wdog_exp;
  logic       ptr_clear;
  logic [7:0] tx_byte;
  logic [7:0] grp_len;
  logic [7:0] ptr_inc;

  // three-stage synchronisers; a level is taken once stages two and three
  // agree, which also rejects single-cycle spikes on the open-drain lines
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_sync  <= 3'h7;
      sda_sync  <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync  <= {scl_sync[1:0], scl_i};
      sda_sync  <= {sda_sync[1:0], sda_i};
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f_reg <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f_reg <= sda_sync[2];
      end
    end
  end

  // bus conditions and transfer events
  assign scl_rise  = scl_f_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_f_reg & scl_d_reg;
  assign start_det = scl_f_reg & scl_d_reg & ~sda_f_reg & sda_d_reg;
  assign stop_det  = scl_f_reg & scl_d_reg & sda_f_reg & ~sda_d_reg;
  assign fall8     = scl_fall & (bit_cnt_reg == sei_pkg::BITS_PER_BYTE);
  assign addr_done = (st_reg == sei_pkg::S_ADDR) & fall8;
  assign wa_done   = (st_reg == sei_pkg::S_WBYTE) & fall8 & first_reg;
  assign wd_done   = (st_reg == sei_pkg::S_WBYTE) & fall8 & ~first_reg;
  assign tx_load   = scl_fall & (((st_reg == sei_pkg::S_AACK) & rd_reg) |
                     ((st_reg == sei_pkg::S_RACK) & mack_reg));

  // command buffer fill level
  assign cmd_full = (in_cnt_reg != 8'h00) & (in_cnt_reg >= count_reg);
  assign cmd_part = (in_cnt_reg != 8'h00) & ~cmd_full;
  // write packets always accepted when awake; reads refused while only part of a command is held
  assign addr_ok  = (shift_reg[7:1] == bus_addr_i) &
                    (pw_reg == sei_pkg::PW_AWAKE) &
                    (~shift_reg[0] | ~cmd_part);

  // actions taken when a stop closes a packet
  assign cmd_go   = stop_det & (pw_reg == sei_pkg::PW_AWAKE) &
                    cmd_full;
  assign go_sleep = stop_det & (pw_reg == sei_pkg::PW_AWAKE) &
                    (func_reg == sei_pkg::FN_SLEEP);
  assign go_idle  = stop_det & (pw_reg == sei_pkg::PW_AWAKE) &
                    (func_reg == sei_pkg::FN_IDLE);
  assign wdog_exp = (wdog_cnt_reg >= WATCHDOG_CYC - 1) &
                    ((pw_reg == sei_pkg::PW_AWAKE) |
                     (pw_reg == sei_pkg::PW_BUSY));
  assign ptr_clear = (wa_done & (shift_reg == sei_pkg::FN_RESET)) |
                     cmd_go | go_sleep | go_idle | wdog_exp;

  // read byte source: result buffer, or the fixed status group
  always_comb begin
    grp_len = sei_pkg::STATUS_GROUP_LEN;
    tx_byte = sei_pkg::STATUS_GROUP_LEN;
    if (out_buf_i.result_valid) begin
      grp_len = out_buf_i.result_len;
      tx_byte = out_buf_i.data;
    end else begin
      case (out_ptr_reg[1:0])
        2'h0:    tx_byte = sei_pkg::STATUS_GROUP_LEN;
        2'h1:    tx_byte = out_buf_i.status;
        2'h2:    tx_byte = out_buf_i.crc[7:0];
        default: tx_byte = out_buf_i.crc[15:8];
      endcase
    end
  end
  // the pointer wraps at the group end so the group can be read again
  assign ptr_inc = ((out_ptr_reg + 8'h01) >= grp_len) ? sei_pkg::PTR_RESET :
                   out_ptr_reg + 8'h01;

  // bit-level engine; held quiet unless the port is awake or busy
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg      <= sei_pkg::S_WAIT;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      first_reg   <= 1'b0;
      rd_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      oe_n_reg    <= 1'b1;
    end else if ((pw_reg != sei_pkg::PW_AWAKE) &&
                 (pw_reg != sei_pkg::PW_BUSY)) begin
      st_reg   <= sei_pkg::S_WAIT;
      oe_n_reg <= 1'b1;
    end else if (start_det) begin
      // a repeated start also ends the nine-clock recovery sequence
      st_reg      <= sei_pkg::S_ADDR;
      bit_cnt_reg <= 4'h0;
      oe_n_reg    <= 1'b1;
    end else if (stop_det) begin
      st_reg   <= sei_pkg::S_WAIT;
      oe_n_reg <= 1'b1;
    end else begin
      if (scl_rise) begin
        shift_reg   <= {shift_reg[6:0], sda_f_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (st_reg == sei_pkg::S_RACK) begin
          mack_reg <= ~sda_f_reg;
        end
      end
      case (st_reg)
        sei_pkg::S_ADDR: begin
          if (addr_done) begin
            rd_reg <= shift_reg[0];
            if (addr_ok) begin
              st_reg   <= sei_pkg::S_AACK;
              oe_n_reg <= 1'b0;
            end else begin
              st_reg <= sei_pkg::S_WAIT;
            end
          end
        end
        sei_pkg::S_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            first_reg   <= 1'b1;
            if (rd_reg) begin
              st_reg   <= sei_pkg::S_RBIT;
              tx_reg   <= tx_byte;
              oe_n_reg <= tx_byte[7];
            end else begin
              st_reg   <= sei_pkg::S_WBYTE;
              oe_n_reg <= 1'b1;
            end
          end
        end
        sei_pkg::S_WBYTE: begin
          if (fall8) begin
            first_reg <= 1'b0;
            // reserved selectors are not acknowledged
            if (first_reg && (shift_reg > sei_pkg::FN_COMMAND)) begin
              st_reg <= sei_pkg::S_WAIT;
            end else begin
              st_reg   <= sei_pkg::S_WACK;
              oe_n_reg <= 1'b0;
            end
          end
        end
        sei_pkg::S_WACK: begin
          if (scl_fall) begin
            st_reg      <= sei_pkg::S_WBYTE;
            bit_cnt_reg <= 4'h0;
            oe_n_reg    <= 1'b1;
          end
        end
        sei_pkg::S_RBIT: begin
          if (fall8) begin
            st_reg   <= sei_pkg::S_RACK;
            oe_n_reg <= 1'b1;
          end else if (scl_fall) begin
            tx_reg   <= {tx_reg[6:0], 1'b0};
            oe_n_reg <= tx_reg[6];
          end
        end
        sei_pkg::S_RACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg) begin
              st_reg   <= sei_pkg::S_RBIT;
              tx_reg   <= tx_byte;
              oe_n_reg <= tx_byte[7];
            end else begin
              st_reg <= sei_pkg::S_WAIT;
            end
          end
        end
        default: begin
          oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // packet function selector, cleared by each start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      func_reg <= sei_pkg::FN_NONE;
    end else if (start_det || (pw_reg != sei_pkg::PW_AWAKE)) begin
      func_reg <= sei_pkg::FN_NONE;
    end else if (wa_done) begin
      func_reg <= shift_reg;
    end
  end

  // input command buffer fill; bytes past the count are dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_cnt_reg <= 8'h00;
      count_reg  <= 8'h00;
      in_wr_reg  <= '0;
    end else begin
      in_wr_reg.valid <= 1'b0;
      if (ptr_clear) begin
        in_cnt_reg <= sei_pkg::PTR_RESET;
      end else if (wd_done && (func_reg == sei_pkg::FN_COMMAND) &&
                   !cmd_full) begin
        in_wr_reg.valid <= 1'b1;
        in_wr_reg.idx   <= in_cnt_reg;
        in_wr_reg.data  <= shift_reg;
        in_cnt_reg      <= in_cnt_reg + 8'h01;
        if (in_cnt_reg == 8'h00) begin
          count_reg <= shift_reg;
        end
      end
    end
  end

  // output buffer read pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_ptr_reg <= sei_pkg::PTR_RESET;
    end else if (ptr_clear) begin
      out_ptr_reg <= sei_pkg::PTR_RESET;
    end else if (tx_load) begin
      out_ptr_reg <= ptr_inc;
    end
  end

  // power state; powers up asleep and waits for a wake pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pw_reg         <= sei_pkg::PW_SLEEP;
      wake_cnt_reg   <= 32'h0;
      vol_clear_reg  <= 1'b0;
      exec_start_reg <= 1'b0;
    end else begin
      vol_clear_reg  <= 1'b0;
      exec_start_reg <= 1'b0;
      case (pw_reg)
        sei_pkg::PW_SLEEP, sei_pkg::PW_IDLE: begin
          // data low long enough, then released, counts as a wake
          if (!sda_f_reg) begin
            if (wake_cnt_reg < sei_pkg::WAKE_LOW_CYC) begin
              wake_cnt_reg <= wake_cnt_reg + 32'h1;
            end
          end else begin
            wake_cnt_reg <= 32'h0;
            if (wake_cnt_reg >= sei_pkg::WAKE_LOW_CYC) begin
              pw_reg <= sei_pkg::PW_WAKE;
            end
          end
        end
        sei_pkg::PW_WAKE: begin
          // clock line is ignored until the wake-high delay has passed
          wake_cnt_reg <= wake_cnt_reg + 32'h1;
          if (wake_cnt_reg >= WAKE_HIGH_CYC - 1) begin
            wake_cnt_reg <= 32'h0;
            pw_reg       <= sei_pkg::PW_AWAKE;
          end
        end
        sei_pkg::PW_AWAKE: begin
          if (wdog_exp || go_sleep) begin
            pw_reg        <= sei_pkg::PW_SLEEP;
            vol_clear_reg <= 1'b1;
          end else if (go_idle) begin
            pw_reg <= sei_pkg::PW_IDLE;
          end else if (cmd_go) begin
            pw_reg         <= sei_pkg::PW_BUSY;
            exec_start_reg <= 1'b1;
          end
        end
        sei_pkg::PW_BUSY: begin
          if (wdog_exp) begin
            pw_reg        <= sei_pkg::PW_SLEEP;
            vol_clear_reg <= 1'b1;
          end else if (exec_done_i) begin
            pw_reg <= sei_pkg::PW_AWAKE;
          end
        end
        default: begin
          pw_reg <= sei_pkg::PW_SLEEP;
        end
      endcase
    end
  end

  // watchdog runs only while awake or busy; idle stops and resets it
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdog_cnt_reg <= 32'h0;
    end else if ((pw_reg == sei_pkg::PW_AWAKE) ||
                 (pw_reg == sei_pkg::PW_BUSY)) begin
      wdog_cnt_reg <= wdog_cnt_reg + 32'h1;
    end else begin
      wdog_cnt_reg <= 32'h0;
    end
  end

  // the pad only ever pulls low; release lets the pull-up read 0xFF
  assign sda_o        = 1'b0;
  assign sda_oe_n_o   = oe_n_reg;
  assign out_idx_o    = out_ptr_reg;
  assign in_wr_o      = in_wr_reg;
  assign exec_start_o = exec_start_reg;
  assign vol_clear_o  = vol_clear_reg;
  assign awake_o      = (pw_reg == sei_pkg::PW_AWAKE);
  assign idle_o       = (pw_reg == sei_pkg::PW_IDLE);
  assign busy_o       = (pw_reg == sei_pkg::PW_BUSY);

endmodule

// ===== design/sei_pkg.sv
package sei_pkg;

  // clock rate and documented times, each count derived from its time
  localparam int unsigned CLK_KHZ        = 40000;
  localparam int unsigned WAKE_LOW_US    = 60;
  localparam int unsigned WAKE_HIGH_US   = 1500;
  localparam int unsigned WATCHDOG_MS    = 1300;
  // least time, rounded up to whole cycles
  localparam int unsigned WAKE_LOW_CYC   = (WAKE_LOW_US * CLK_KHZ + 999) / 1000;
  localparam int unsigned WAKE_HIGH_CYC  = (WAKE_HIGH_US * CLK_KHZ + 999) / 1000;
  // longest time, rounded down
  localparam int unsigned WATCHDOG_CYC   = WATCHDOG_MS * CLK_KHZ;

  // word address selector values
  localparam logic [7:0] FN_RESET   = 8'h00;
  localparam logic [7:0] FN_SLEEP   = 8'h01;
  localparam logic [7:0] FN_IDLE    = 8'h02;
  localparam logic [7:0] FN_COMMAND = 8'h03;
  localparam logic [7:0] FN_NONE    = 8'hFF;

  // status group returned when no result is held
  localparam logic [7:0] STATUS_GROUP_LEN = 8'h04;
  localparam logic [7:0] PTR_RESET        = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  // byte written into the input command buffer
  typedef struct packed {
    logic       valid;
    logic [7:0] idx;
    logic [7:0] data;
  } sei_in_wr_s;

  // view of the output buffer seen by the read path
  typedef struct packed {
    logic        result_valid;
    logic [7:0]  result_len;
    logic [7:0]  data;
    logic [7:0]  status;
    logic [15:0] crc;
  } sei_out_s;

  typedef enum logic [8:0] {
    S_WAIT  = 9'h001,
    S_ADDR  = 9'h002,
    S_AACK  = 9'h004,
    S_WBYTE = 9'h008,
    S_WACK  = 9'h010,
    S_RBIT  = 9'h020,
    S_RACK  = 9'h040,
    S_SPARE = 9'h080,
    S_HOLD  = 9'h100
  } sei_bus_e;

  typedef enum logic [4:0] {
    PW_SLEEP = 5'h01,
    PW_WAKE  = 5'h02,
    PW_AWAKE = 5'h04,
    PW_BUSY  = 5'h08,
    PW_IDLE  = 5'h10
  } sei_pwr_e;

endpackage

// ===== tb/sei_i2c_port_checker.sv
`timescale 1ns/1ps
module sei_i2c_port_checker #(
  parameter int unsigned WAKE_HIGH_CYC = 20,
  parameter int unsigned WATCHDOG_CYC  = 2000
) (
  input wire logic                clk_i,
  input wire logic                nrst_i,
  input wire logic                scl_i,
  input wire logic                sda_i,
  input wire logic                sda_o,
  input wire logic                sda_oe_n_o,
  input wire logic [6:0]          bus_addr_i,
  input wire sei_pkg::sei_out_s   out_buf_i,
  input wire logic [7:0]          out_idx_o,
  input wire sei_pkg::sei_in_wr_s in_wr_o,
  input wire logic                exec_start_o,
  input wire logic                exec_done_i,
  input wire logic                vol_clear_o,
  input wire logic                awake_o,
  input wire logic                idle_o,
  input wire logic                busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic        asleep;
  logic [7:0]  last_idx_reg;
  logic [31:0] wd_reg;
  assign asleep = !awake_o && !busy_o && !idle_o;
  // last stored slot, so a skipped or repeated slot shows up
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_idx_reg <= 8'h00;
    end else if (in_wr_o.valid) begin
      last_idx_reg <= in_wr_o.idx;
    end
  end
  // cycles awake since the last rest; idle must stop the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wd_reg <= 32'h0000_0000;
    end else begin
      wd_reg <= (awake_o || busy_o) ? wd_reg + 32'h1 : 32'h0000_0000;
    end
  end
  // start pulse and busy rise on one edge, right after an awake cycle
  sequence s_launch; exec_start_o && busy_o && $past(awake_o); endsequence
  // one cycle after launch busy is still set, unless done was reported or the watchdog fired
  sequence s_run; busy_o || $past(exec_done_i) || vol_clear_o; endsequence
  property p_exec_busy; exec_start_o |-> s_launch ##1 s_run; endproperty
  a_exec_busy: assert property (p_exec_busy)
    else $error("execution start without busy");
  property p_done; busy_o && exec_done_i |-> ##[1:2] awake_o; endproperty
  a_done: assert property (p_done)
    else $error("busy kept after done");
  property p_clear; vol_clear_o |-> ##[0:1] asleep; endproperty
  a_clear: assert property (p_clear)
    else $error("clear without sleep");
  property p_sleep_quiet;
    asleep && $past(asleep) |-> sda_oe_n_o && !in_wr_o.valid && !exec_start_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("activity while asleep");
  property p_idle_quiet;
    idle_o && $past(idle_o) |-> sda_oe_n_o && !in_wr_o.valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("activity while idle");
  property p_ack_awake; $fell(sda_oe_n_o) |-> awake_o; endproperty
  a_ack_awake: assert property (p_ack_awake)
    else $error("line pulled while not awake");
  property p_busy_nowr; busy_o |-> !in_wr_o.valid; endproperty
  a_busy_nowr: assert property (p_busy_nowr)
    else $error("byte stored while busy");
  property p_idx_seq;
    in_wr_o.valid && in_wr_o.idx != 8'h00 |->
      in_wr_o.idx == last_idx_reg + 8'h01;
  endproperty
  a_idx_seq: assert property (p_idx_seq)
    else $error("input slot not consecutive");
  property p_watchdog; wd_reg <= WATCHDOG_CYC + 2; endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("awake past watchdog interval");
  property p_wake_hold; $fell(idle_o) |-> !awake_o [*8]; endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("awake too soon after idle");
endmodule

bind sei_i2c_port sei_i2c_port_checker #(
  .WAKE_HIGH_CYC(WAKE_HIGH_CYC), .WATCHDOG_CYC(WATCHDOG_CYC)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .bus_addr_i(bus_addr_i),
  .out_buf_i(out_buf_i), .out_idx_o(out_idx_o), .in_wr_o(in_wr_o),
  .exec_start_o(exec_start_o), .exec_done_i(exec_done_i),
  .vol_clear_o(vol_clear_o), .awake_o(awake_o), .idle_o(idle_o),
  .busy_o(busy_o));

// ===== tb/sei_host_model.sv
`timescale 1ns/1ps
module sei_host_model #(
  parameter int HALF = 10
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // released lines read high through the pull-up
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // clock edge first, data later, so no false start or stop appears
  task automatic drv(input logic c, input logic d);
    @(posedge clk_i);
    scl_o <= c;
    repeat (HALF / 2) @(posedge clk_i);
    sda_o <= d;
    repeat (HALF) @(posedge clk_i);
  endtask
  task automatic start();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
  endtask
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask
  // one byte msb first, then the ninth clock; wd ff reads the device
  task automatic xfer(input logic [7:0] wd, input logic mack,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv(1'b0, wd[i]);
      drv(1'b1, wd[i]);
      rd[i] = sda_i;
    end
    drv(1'b0, mack);
    drv(1'b1, mack);
    ack = !sda_i;
  endtask
  // data held low long enough, then the settle wait before any transfer
  task automatic wake(input int low, input int settle);
    @(posedge clk_i);
    sda_o <= 1'b0;
    repeat (low) @(posedge clk_i);
    sda_o <= 1'b1;
    repeat (settle) @(posedge clk_i);
  endtask
  // bus reset: start, nine released clocks, start, stop
  task automatic recover();
    start();
    for (int i = 0; i < 9; i++) begin
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
    end
    start();
    stop();
  endtask
endmodule

// ===== tb/test_sei_i2c_port.sv
`timescale 1ns/1ps
module test_sei_i2c_port;
  localparam int unsigned WH = 20;
  localparam int unsigned WD = 30000;
  logic                clk_i = 1'b0;
  logic                nrst_i = 1'b0;
  logic [6:0]          addr = 7'h00;
  logic                exec_done = 1'b0;
  logic                rv = 1'b0;
  logic [7:0]          rlen = 8'h00;
  logic [7:0]          stat = 8'h00;
  logic [15:0]         crc = 16'h0000;
  logic [7:0]          mem [0:3] = '{default: 8'h00};
  logic [7:0]          cmd [0:3];
  sei_pkg::sei_out_s   ob;
  sei_pkg::sei_in_wr_s wr_o;
  logic [7:0]          idx_o;
  logic                scl, sda_h, sda_oe_n, sda_d, sda_w;
  logic                exec_s, clr, awake, idle, busy;
  logic [15:0]         expq [$];
  int                  err_total = 0;
  int                  n_compared = 0;
  int                  n_exec = 0, n_clr = 0, cnt = 0, need = 0, ptr = 0;
  int                  seed;

  // wired-and of both parties on the pulled-up data line
  assign sda_w = sda_h & (sda_oe_n | sda_d);
  always_comb ob = '{rv, rlen, mem[idx_o[1:0]], stat, crc};
  sei_i2c_port #(.WAKE_HIGH_CYC(WH), .WATCHDOG_CYC(WD)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .bus_addr_i(addr),
    .out_buf_i(ob), .out_idx_o(idx_o), .in_wr_o(wr_o),
    .exec_start_o(exec_s), .exec_done_i(exec_done), .vol_clear_o(clr),
    .awake_o(awake), .idle_o(idle), .busy_o(busy));
  sei_host_model host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_o(sda_h));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic cmp_b(input logic g, input logic e);
    #1;
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // expected output byte at the modelled pointer
  function automatic logic [7:0] exp_byte();
    if (rv) return mem[ptr];
    case (ptr)
      0: return 8'h04;
      1: return stat;
      2: return crc[7:0];
      default: return crc[15:8];
    endcase
  endfunction
  // the oldest note is matched against each stored byte
  always @(posedge clk_i) begin
    if (exec_s === 1'b1) n_exec++;
    if (clr === 1'b1) n_clr++;
    if (wr_o.valid === 1'b1) begin
      if (expq.size() == 0) cmp_w({wr_o.idx, wr_o.data}, 16'hXXXX);
      else cmp_w({wr_o.idx, wr_o.data}, expq.pop_front());
    end
  end
  task automatic wr(input logic [7:0] sel, input int n, input logic [6:0] a);
    logic [7:0] d;
    logic       ack;
    host.start();
    host.xfer({a, 1'b0}, 1'b1, d, ack);
    cmp_b(ack, a == addr);
    if (ack) begin
      host.xfer(sel, 1'b1, d, ack);
      cmp_b(ack, 1'b1);
      if (sel != 8'h03) cnt = 0;
      if (sel != 8'h03) ptr = 0;
      for (int i = 0; i < n; i++) begin
        if (cnt == 0 || cnt < need) begin
          if (cnt == 0) need = cmd[i];
          expq.push_back({cnt[7:0], cmd[i]});
          cnt++;
        end
        host.xfer(cmd[i], 1'b1, d, ack);
      end
    end
    host.stop();
  endtask
  task automatic rd(input int n, input logic e_ack);
    logic [7:0] d;
    logic       ack, a2;
    host.start();
    host.xfer({addr, 1'b1}, 1'b1, d, ack);
    cmp_b(ack, e_ack);
    if (ack) begin
      for (int i = 0; i < n; i++) begin
        host.xfer(8'hFF, i == n - 1, d, a2);
        cmp_w({8'h00, d}, {8'h00, exp_byte()});
        ptr = (ptr + 1) % (rv ? int'(rlen) : 4);
      end
    end
    host.stop();
  endtask
  initial begin
    seed = $urandom(42321);
    @(posedge clk_i);
    addr <= 7'($urandom);
    stat <= 8'($urandom);
    crc <= 16'($urandom);
    for (int i = 0; i < 4; i++) mem[i] <= 8'($urandom);
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(1, 1'b0);
    host.wake(2500, WH + 30);
    cmp_b(awake, 1'b1);
    rd(4, 1'b1);
    rd(2, 1'b1);
    wr(8'h00, 0, addr ^ 7'h01);
    wr(8'h00, 0, addr);
    rd(1, 1'b1);
    cmd = '{8'h05, 8'($urandom), 8'($urandom), 8'h00};
    wr(8'h03, 2, addr);
    rd(1, 1'b0);
    wr(8'h03, 2, addr);
    host.recover();
    rd(1, 1'b0);
    wr(8'h00, 0, addr);
    rd(1, 1'b1);
    cmd = '{8'h03, 8'($urandom), 8'($urandom), 8'($urandom)};
    wr(8'h03, 4, addr);
    cmp_b(busy, 1'b1);
    cmp_w(16'(n_exec), 16'h0001);
    rd(1, 1'b0);
    @(posedge clk_i);
    rv <= 1'b1;
    rlen <= 8'h03;
    exec_done <= 1'b1;
    @(posedge clk_i);
    exec_done <= 1'b0;
    repeat (4) @(posedge clk_i);
    cmp_b(awake, 1'b1);
    // a launched command rewinds the output pointer to the group start
    ptr = 0;
    rd(1, 1'b1);
    wr(8'h00, 0, addr);
    rd(2, 1'b1);
    rd(2, 1'b1);
    wr(8'h02, 0, addr);
    cmp_b(idle, 1'b1);
    rd(1, 1'b0);
    host.wake(2500, WH + 30);
    cmp_b(awake, 1'b1);
    rd(1, 1'b1);
    wr(8'h01, 0, addr);
    cmp_b(awake, 1'b0);
    cmp_w(16'(n_clr), 16'h0001);
    @(posedge clk_i);
    rv <= 1'b0;
    host.wake(2500, WH + 30);
    repeat (WD + 20) @(posedge clk_i);
    cmp_b(awake, 1'b0);
    cmp_w(16'(n_clr), 16'h0002);
    cmp_w(16'(expq.size()), 16'h0000);
    conclude();
  end
  // a hang is cut short well past the expected run of about 55000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule
